// *** logic/lcd_pkg.sv ***
package lcd_pkg;

  // ----------------------------------------------------------------
  // Slave address and command byte patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] LCD_ADDR_HI      = 6'h1C;  // Address bits 7..2 of 0111 00x
  localparam logic [1:0] LCD_CMD_PTR_PAT  = 2'h0;   // Bits 6..5
  localparam logic [3:0] LCD_CMD_DEV_PAT  = 4'hC;   // Bits 6..3
  localparam logic [4:0] LCD_CMD_BANK_PAT = 5'h1E;  // Bits 6..2
  localparam logic [3:0] LCD_CMD_BLNK_PAT = 4'hE;   // Bits 6..3

  // ----------------------------------------------------------------
  // Multiplex drive mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LCD_MUX_STATIC = 2'h1;
  localparam logic [1:0] LCD_MUX_1_2    = 2'h2;
  localparam logic [1:0] LCD_MUX_1_3    = 2'h3;
  localparam logic [1:0] LCD_MUX_1_4    = 2'h0;

  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int         LCD_RAM_DEPTH   = 32;
  localparam int         LCD_RAM_WIDTH   = 4;
  localparam int         LCD_SYNC_BITS   = 6;
  localparam logic [3:0] LCD_LAST_BIT    = 4'h7;   // Bit count when the byte completes
  localparam logic [3:0] LCD_ACK_BIT     = 4'h8;   // Bit count during the ack slot
  localparam logic [3:0] LCD_END_BIT     = 4'h9;   // Bit count after the ack pulse
  localparam logic [2:0] LCD_WR_BITS     = 3'h7;   // Last bit index of a data byte
  localparam logic [4:0] LCD_PTR_RST     = 5'h00;
  localparam logic [2:0] LCD_SUB_RST     = 3'h0;
  localparam logic [1:0] LCD_BANK_HI     = 2'h2;   // Row offset of the upper bank

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    LCD_ST_IDLE = 3'b000,
    LCD_ST_ADDR = 3'b001,
    LCD_ST_CMD  = 3'b010,
    LCD_ST_DATA = 3'b011,
    LCD_ST_SKIP = 3'b100
  } lcd_state_e;

  typedef enum logic [2:0]
  {
    LCD_CMD_NONE  = 3'b000,
    LCD_CMD_PTR   = 3'b001,
    LCD_CMD_DEV   = 3'b010,
    LCD_CMD_BANK  = 3'b011,
    LCD_CMD_BLINK = 3'b100
  } lcd_cmd_e;

  typedef struct packed
  {
    logic       in_bank;
    logic       out_bank;
    logic       alt_bank_blink;
    logic [1:0] blink_rate_sel;
  } lcd_disp_cfg_s;

  localparam lcd_disp_cfg_s LCD_CFG_RST = '{1'b0, 1'b0, 1'b0, 2'h0};

endpackage

// *** logic/lcd_disp_ram.sv ***
`timescale 1ns/1ps

module lcd_disp_ram
#(
  parameter int DEPTH = 32,
  parameter int WIDTH = 4
)
(
  // Clock
  input  wire logic                     clk_sys_in,
  // Bit write port
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [$clog2(WIDTH)-1:0] wr_bit_in,
  input  wire logic                     wr_val_in,
  // Word read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Single bit write, keeps the other rows of the word
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in][wr_bit_in] <= wr_val_in;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys_in)
  begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

// *** logic/lcd_cmd_port.sv ***
`timescale 1ns/1ps

module lcd_cmd_port
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // Two-wire bus pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  // Address straps
  input  wire logic                  addr_lsb_strap_in,
  input  wire logic                  hw_subaddr_pin0_in,
  input  wire logic                  hw_subaddr_pin1_in,
  input  wire logic                  hw_subaddr_pin2_in,
  // Drive mode from the mode logic
  input  wire logic [1:0]            mux_mode_in,
  // Display read side
  input  wire logic [4:0]            disp_rd_addr_in,
  output logic      [3:0]            disp_rd_data_out,
  // Status
  output lcd_pkg::lcd_disp_cfg_s     disp_cfg_out,
  output logic      [4:0]            data_ptr_out,
  output logic      [2:0]            subaddr_out,
  output logic                       busy_out
);

  import lcd_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Command class of a byte
  function automatic lcd_cmd_e cmd_class(input logic [7:0] b);
    lcd_cmd_e c;
    c = LCD_CMD_NONE;
    if (b[6:5] == LCD_CMD_PTR_PAT)
      c = LCD_CMD_PTR;
    else if (b[6:3] == LCD_CMD_DEV_PAT)
      c = LCD_CMD_DEV;
    else if (b[6:2] == LCD_CMD_BANK_PAT)
      c = LCD_CMD_BANK;
    else if (b[6:3] == LCD_CMD_BLNK_PAT)
      c = LCD_CMD_BLINK;
    return c;
  endfunction

  // True in the 1:3 and 1:4 modes
  function automatic logic mux_wide(input logic [1:0] m);
    return (m == LCD_MUX_1_3) || (m == LCD_MUX_1_4);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and filter
  // ----------------------------------------------------------------
  logic [LCD_SYNC_BITS-1:0] pins;
  logic [LCD_SYNC_BITS-1:0] s1_reg;
  logic [LCD_SYNC_BITS-1:0] s2_reg;
  logic [LCD_SYNC_BITS-1:0] s3_reg;
  logic [LCD_SYNC_BITS-1:0] filt_reg;

  assign pins = {hw_subaddr_pin2_in, hw_subaddr_pin1_in, hw_subaddr_pin0_in,
                 addr_lsb_strap_in, sda_in, scl_in};

  // Three stages; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < LCD_SYNC_BITS; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          s1_reg[gi]   <= 1'b1;
          s2_reg[gi]   <= 1'b1;
          s3_reg[gi]   <= 1'b1;
          filt_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
          begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic       scl_f;
  logic       sda_f;
  logic       strap_f;
  logic [2:0] sub_pins_f;
  logic       scl_d_reg;
  logic       sda_d_reg;

  assign scl_f      = filt_reg[0];
  assign sda_f      = filt_reg[1];
  assign strap_f    = filt_reg[2];
  assign sub_pins_f = filt_reg[5:3];

  // Previous filtered levels for edge finding
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Bus events
  assign scl_rise  = scl_f && !scl_d_reg;
  assign scl_fall  = !scl_f && scl_d_reg;
  assign start_det = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_det  = scl_f && scl_d_reg && !sda_d_reg && sda_f;

  // ----------------------------------------------------------------
  // Bit engine and acknowledge
  // ----------------------------------------------------------------
  lcd_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic       ack_pend_reg;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic       sub_match;
  logic       ack_next;

  assign rx_byte   = {shift_reg, sda_f};
  assign sub_match = (subaddr_out == sub_pins_f);
  assign byte_done = scl_rise && (bit_cnt_reg == LCD_LAST_BIT) &&
                     (state_reg != LCD_ST_IDLE) && (state_reg != LCD_ST_SKIP);

  // Ack decision for the byte just completed
  always_comb
  begin
    ack_next = 1'b0;
    case (state_reg)
      LCD_ST_ADDR:
        ack_next = (rx_byte[7:2] == LCD_ADDR_HI) && (rx_byte[1] == strap_f) &&
                   !rx_byte[0];
      LCD_ST_CMD:
        ack_next = 1'b1;
      LCD_ST_DATA:
        ack_next = sub_match;
      default:
        ack_next = 1'b0;
    endcase
  end

  // Shift in bits on rising clock, ack slot on the following low phase
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 7'h00;
      ack_pend_reg <= 1'b0;
      sda_oe_out   <= 1'b0;
      sda_out      <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      bit_cnt_reg  <= 4'h0;
      ack_pend_reg <= 1'b0;
      sda_oe_out   <= 1'b0;
    end
    else
    begin
      if (scl_rise && bit_cnt_reg < LCD_END_BIT)
      begin
        shift_reg   <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (byte_done)
      begin
        ack_pend_reg <= ack_next;
      end
      if (scl_fall && bit_cnt_reg == LCD_ACK_BIT)
      begin
        sda_oe_out <= ack_pend_reg;
      end
      else if (scl_fall && bit_cnt_reg == LCD_END_BIT)
      begin
        sda_oe_out   <= 1'b0;
        ack_pend_reg <= 1'b0;
        bit_cnt_reg  <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= LCD_ST_IDLE;
    end
    else if (start_det)
    begin
      state_reg <= LCD_ST_ADDR;
    end
    else if (stop_det)
    begin
      state_reg <= LCD_ST_IDLE;
    end
    else if (byte_done)
    begin
      case (state_reg)
        LCD_ST_ADDR:
          state_reg <= ack_next ? LCD_ST_CMD : LCD_ST_SKIP;
        LCD_ST_CMD:
          state_reg <= rx_byte[7] ? LCD_ST_CMD : LCD_ST_DATA;
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // Busy flag registered straight onto the port, one cycle behind the state
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      busy_out <= 1'b0;
    else
      busy_out <= (state_reg != LCD_ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  logic     cmd_stb;
  lcd_cmd_e cmd;
  logic     ab_raw_reg;

  assign cmd_stb = byte_done && (state_reg == LCD_ST_CMD);
  assign cmd     = cmd_class(rx_byte);

  // Bank and blink settings
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      disp_cfg_out <= LCD_CFG_RST;
      ab_raw_reg   <= 1'b0;
    end
    else
    begin
      if (cmd_stb && cmd == LCD_CMD_BANK && !mux_wide(mux_mode_in))
      begin
        disp_cfg_out.in_bank  <= rx_byte[1];
        disp_cfg_out.out_bank <= rx_byte[0];
      end
      if (cmd_stb && cmd == LCD_CMD_BLINK)
      begin
        ab_raw_reg                  <= rx_byte[2];
        disp_cfg_out.blink_rate_sel <= rx_byte[1:0];
      end
      disp_cfg_out.alt_bank_blink <= ab_raw_reg && !mux_wide(mux_mode_in);
    end
  end

  // ----------------------------------------------------------------
  // Data writer: one RAM bit per cycle in filling order
  // ----------------------------------------------------------------
  logic       wr_busy_reg;
  logic [2:0] wr_idx_reg;
  logic [7:0] wr_byte_reg;
  logic [1:0] row_reg;
  logic [1:0] row_last;
  logic [1:0] row_base;
  logic       wr_en;

  // Rows per address follow the drive mode
  always_comb
  begin
    case (mux_mode_in)
      LCD_MUX_STATIC: row_last = 2'h0;
      LCD_MUX_1_2:    row_last = 2'h1;
      LCD_MUX_1_3:    row_last = 2'h2;
      default:        row_last = 2'h3;
    endcase
    row_base = (disp_cfg_out.in_bank && !mux_wide(mux_mode_in)) ? LCD_BANK_HI : 2'h0;
  end

  assign wr_en = wr_busy_reg && sub_match;

  // Byte capture and bit index
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_busy_reg <= 1'b0;
      wr_idx_reg  <= 3'h0;
      wr_byte_reg <= 8'h00;
    end
    else if (byte_done && state_reg == LCD_ST_DATA)
    begin
      wr_busy_reg <= 1'b1;
      wr_idx_reg  <= 3'h0;
      wr_byte_reg <= rx_byte;
    end
    else if (wr_busy_reg)
    begin
      wr_byte_reg <= {wr_byte_reg[6:0], 1'b0};
      wr_idx_reg  <= wr_idx_reg + 3'h1;
      if (wr_idx_reg == LCD_WR_BITS)
        wr_busy_reg <= 1'b0;
    end
  end

  // Data pointer, subaddress counter and row within the address
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      data_ptr_out <= LCD_PTR_RST;
      subaddr_out  <= LCD_SUB_RST;
      row_reg      <= 2'h0;
    end
    else if (cmd_stb && cmd == LCD_CMD_PTR)
    begin
      data_ptr_out <= rx_byte[4:0];
      row_reg      <= 2'h0;
    end
    else if (cmd_stb && cmd == LCD_CMD_DEV)
    begin
      subaddr_out <= rx_byte[2:0];
    end
    else if (wr_busy_reg)
    begin
      if (row_reg >= row_last)
      begin
        row_reg      <= 2'h0;
        data_ptr_out <= data_ptr_out + 5'h01;
        if (data_ptr_out == 5'h1F)
          subaddr_out <= subaddr_out + 3'h1;
      end
      else
      begin
        row_reg <= row_reg + 2'h1;
      end
    end
  end

  lcd_disp_ram
  #(
    .DEPTH (LCD_RAM_DEPTH),
    .WIDTH (LCD_RAM_WIDTH)
  )
  u_ram
  (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (data_ptr_out),
    .wr_bit_in   (2'(row_base + row_reg)),
    .wr_val_in   (wr_byte_reg[7]),
    .rd_addr_in  (disp_rd_addr_in),
    .rd_data_out (disp_rd_data_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_on_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(sda_oe_out) |-> !scl_f) else $error("ack raised with clock high");
  a_ack_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    sda_oe_out && scl_f && !stop_det && !start_det |=> sda_oe_out) else $error("ack dropped early");
  a_no_data_out: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    sda_out == 1'b0) else $error("data line driven high");
  a_skip_silent: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    state_reg == LCD_ST_SKIP |-> !sda_oe_out && !wr_en) else $error("ignored transfer acted");
  a_start_addr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    start_det |=> state_reg == LCD_ST_ADDR && bit_cnt_reg == 4'h0) else $error("start not taken");
  a_stop_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    stop_det |=> state_reg == LCD_ST_IDLE && !sda_oe_out) else $error("stop not taken");
  a_bank_ignore: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_stb && mux_wide(mux_mode_in) |=> $stable(disp_cfg_out.in_bank)) else $error("bank changed");
  a_alt_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mux_wide(mux_mode_in) && mux_wide($past(mux_mode_in)) |-> !disp_cfg_out.alt_bank_blink)
    else $error("alternate blink in wide mode");
  a_ptr_load: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_stb && cmd == LCD_CMD_PTR |=> data_ptr_out == $past(rx_byte[4:0])) else $error("pointer not loaded");
  a_data_nack: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    byte_done && state_reg == LCD_ST_DATA && !sub_match |=> !ack_pend_reg) else $error("foreign data acked");
  a_last_cmd: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_stb && !rx_byte[7] |=> state_reg == LCD_ST_DATA) else $error("chain not ended");

endmodule

// *** dv/lcd_bus_master.sv ***
`timescale 1ns/1ps

module lcd_bus_master
#(
  parameter int PHASE_CLKS = 10
)
(
  // Clock and resolved data line
  input  wire logic clk_sys_in,
  input  wire logic sda_in,
  // Bus lines, data high means released
  output logic      scl_out,
  output logic      sda_out
);
  // ----------------------------------------------------------------
  // Bus idles high until the first frame
  // ----------------------------------------------------------------
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Wait a number of falling clock edges
  task automatic pause(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Start or repeated start, from idle or from a low clock
  task automatic bus_start();
    pause(2);
    sda_out = 1'b1;
    pause(PHASE_CLKS);
    scl_out = 1'b1;         // Both lines high before the frame opens
    pause(PHASE_CLKS);
    sda_out = 1'b0;         // Data falls while clock high
    pause(PHASE_CLKS);
    scl_out = 1'b0;
  endtask

  // Stop, leaving the bus idle
  task automatic bus_stop();
    pause(2);
    sda_out = 1'b0;
    pause(PHASE_CLKS);
    scl_out = 1'b1;
    pause(PHASE_CLKS);
    sda_out = 1'b1;         // Data rises while clock high
    pause(PHASE_CLKS);
  endtask

  // One byte MSB first, then the ack pulse; ack must hold the whole high phase
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      pause(2);
      sda_out = b[i];       // Data moves only while the clock is low
      pause(PHASE_CLKS - 2);
      scl_out = 1'b1;
      pause(PHASE_CLKS);
      scl_out = 1'b0;
    end
    pause(2);
    sda_out = 1'b1;
    pause(PHASE_CLKS - 2);
    scl_out = 1'b1;
    ack = 1'b1;
    repeat (PHASE_CLKS)
    begin
      @(negedge clk_sys_in);
      ack = ack & ~sda_in;
    end
    scl_out = 1'b0;
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  import lcd_pkg::*;

  typedef struct packed
  {
    logic [1:0] mode;
    logic [7:0] cmd;
    logic [4:0] cfg;
    logic [4:0] ptr;
    logic [2:0] sub;
  } lcd_tb_row_s;

  typedef struct packed
  {
    logic [7:0] addr;
    logic       strap;
    logic [7:0] cmd;
    logic       ack;
    logic [4:0] ptr;
  } lcd_tb_ref_s;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          clk_sys_in;
  logic          rstn_in;
  logic          strap;
  logic [2:0]    hw_pins;
  logic [1:0]    mux_mode;
  logic [4:0]    rd_addr;
  logic          sda_drv;
  logic          sda_oe;
  logic          scl;
  logic          m_sda;
  wire           sda_line;
  logic [3:0]    rd_data;
  lcd_disp_cfg_s cfg;
  logic [4:0]    ptr;
  logic [2:0]    sub;
  logic          busy;
  int            error_cnt;
  int            n_checks;
  logic [7:0]    pat;

  // Open-drain data line with pull-up
  assign sda_line = m_sda & (sda_oe ? sda_drv : 1'b1);

  // Command rows: mode, command, then expected configuration, pointer, subaddress
  lcd_tb_row_s rows [12] = '{
    '{LCD_MUX_STATIC, 8'h1F, 5'h00, 5'h1F, 3'h0}, '{LCD_MUX_STATIC, 8'h65, 5'h00, 5'h1F, 3'h5},
    '{LCD_MUX_STATIC, 8'h7A, 5'h10, 5'h1F, 3'h5}, '{LCD_MUX_1_2, 8'h79, 5'h08, 5'h1F, 3'h5},
    '{LCD_MUX_1_3, 8'h7B, 5'h08, 5'h1F, 3'h5}, '{LCD_MUX_1_4, 8'h7A, 5'h08, 5'h1F, 3'h5},
    '{LCD_MUX_STATIC, 8'h74, 5'h0C, 5'h1F, 3'h5}, '{LCD_MUX_1_2, 8'h71, 5'h09, 5'h1F, 3'h5},
    '{LCD_MUX_STATIC, 8'h76, 5'h0E, 5'h1F, 3'h5}, '{LCD_MUX_1_3, 8'h77, 5'h0B, 5'h1F, 3'h5},
    '{LCD_MUX_STATIC, 8'h00, 5'h0F, 5'h00, 3'h5}, '{LCD_MUX_STATIC, 8'h40, 5'h0F, 5'h00, 3'h5}};

  // Address rows: address, strap, command, expected ack and pointer
  lcd_tb_ref_s refs [5] = '{'{8'h72, 1'b0, 8'h1F, 1'b0, 5'h02}, '{8'h71, 1'b0, 8'h1F, 1'b0, 5'h02},
    '{8'h40, 1'b0, 8'h1F, 1'b0, 5'h02}, '{8'h70, 1'b1, 8'h1F, 1'b0, 5'h02},
    '{8'h72, 1'b1, 8'h07, 1'b1, 5'h07}};

  // ----------------------------------------------------------------
  // Design and bus master
  // ----------------------------------------------------------------
  lcd_cmd_port u_lcd_cmd_port (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .addr_lsb_strap_in(strap),
    .hw_subaddr_pin0_in(hw_pins[0]), .hw_subaddr_pin1_in(hw_pins[1]), .hw_subaddr_pin2_in(hw_pins[2]),
    .mux_mode_in(mux_mode), .disp_rd_addr_in(rd_addr), .disp_rd_data_out(rd_data),
    .disp_cfg_out(cfg), .data_ptr_out(ptr), .subaddr_out(sub), .busy_out(busy));

  lcd_bus_master u_lcd_bus_master (.clk_sys_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl), .sda_out(m_sda));

  // ----------------------------------------------------------------
  // Clock, helpers and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_lcd_bus_master.put_byte(b, ack);
    check({7'h0, ack}, {7'h0, exp_ack}, "ack");
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Drive value must be low whenever the pin is enabled
  always @(negedge clk_sys_in)
    if (sda_oe === 1'b1)
      check({7'h0, sda_drv}, 8'h00, "sda drive");

  // Cut a hang short
  initial
  begin
    repeat (100000) @(posedge clk_sys_in);
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    rstn_in = 1'b0;
    strap = 1'b0;
    hw_pins = 3'h3;
    mux_mode = LCD_MUX_STATIC;
    rd_addr = 5'h00;
    pat = 8'hA5;
    repeat (12) @(negedge clk_sys_in);
    check({3'h0, cfg}, 8'h00, "reset cfg");
    check({ptr, sub}, 8'h00, "reset ptr and sub");
    check({6'h0, busy, sda_oe}, 8'h00, "reset flags");
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    // Single-command transfers
    foreach (rows[i])
    begin
      mux_mode = rows[i].mode;
      u_lcd_bus_master.bus_start();
      send(8'h70, 1'b1);
      send(rows[i].cmd, 1'b1);
      u_lcd_bus_master.bus_stop();
      check({3'h0, cfg}, {3'h0, rows[i].cfg}, "cfg");
      check({ptr, sub}, {rows[i].ptr, rows[i].sub}, "ptr and sub");
    end
    // Chained commands then data in static mode
    u_lcd_bus_master.bus_start();
    send(8'h70, 1'b1);
    send(8'h85, 1'b1);
    send(8'h63, 1'b1);
    check({7'h0, busy}, 8'h01, "busy");
    send(pat, 1'b1);
    u_lcd_bus_master.bus_stop();
    check({7'h0, busy}, 8'h00, "idle");
    check({ptr, sub}, {5'h0D, 3'h3}, "after data");
    for (int i = 0; i < 8; i++)
    begin
      rd_addr = 5'(5 + i);
      repeat (2) @(negedge clk_sys_in);
      check({7'h0, rd_data[0]}, {7'h0, pat[7 - i]}, "static ram");
    end
    // Four-row data across the pointer wrap, then a foreign subaddress
    mux_mode = LCD_MUX_1_4;
    u_lcd_bus_master.bus_start();
    send(8'h70, 1'b1);
    send(8'h9E, 1'b1);
    send(8'h63, 1'b1);
    send(8'h3C, 1'b1);
    send(8'hFF, 1'b0);
    u_lcd_bus_master.bus_stop();
    check({ptr, sub}, {5'h02, 3'h4}, "wrap");
    rd_addr = 5'h1E;
    repeat (2) @(negedge clk_sys_in);
    check({4'h0, rd_data}, 8'h0C, "ram 30");
    rd_addr = 5'h1F;
    repeat (2) @(negedge clk_sys_in);
    check({4'h0, rd_data}, 8'h03, "ram 31");
    // Foreign addresses, reads and strap mismatch
    foreach (refs[i])
    begin
      strap = refs[i].strap;
      u_lcd_bus_master.bus_start();
      send(refs[i].addr, refs[i].ack);
      send(refs[i].cmd, refs[i].ack);
      u_lcd_bus_master.bus_stop();
      check({3'h0, ptr}, {3'h0, refs[i].ptr}, "ptr");
    end
    // Repeated start decodes a fresh address
    strap = 1'b0;
    u_lcd_bus_master.bus_start();
    send(8'h70, 1'b1);
    send(8'h01, 1'b1);
    u_lcd_bus_master.bus_start();
    send(8'h70, 1'b1);
    send(8'h04, 1'b1);
    u_lcd_bus_master.bus_stop();
    check({3'h0, ptr}, 8'h04, "restart ptr");
    // Second reset in mid-run
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    check({3'h0, cfg}, 8'h00, "second reset");
    check({ptr, sub}, 8'h00, "second reset");
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    check({6'h0, busy, sda_oe}, 8'h00, "after release");
    check({ptr, sub}, 8'h00, "after release");
    stop_test();
  end
endmodule
